// ==== hdl/clk_trim_pkg.sv ====
package clk_trim_pkg;

    // Register offsets on the special function register port
    localparam logic [7:0] PRESCALE_OFS    = 8'hb9;
    localparam logic [7:0] DELAY_CFG_OFS   = 8'hc2;
    localparam logic [7:0] HIGH_TRIM_OFS   = 8'hc3;
    localparam logic [7:0] LOW_TRIM_OFS    = 8'hc4;
    localparam logic [7:0] CLK_STATUS_OFS  = 8'hc5;

    // Values after reset
    localparam logic [1:0] PRESCALE_RST    = 2'h0;
    localparam logic [2:0] DELAY_CODE_RST  = 3'h3;
    localparam logic [7:0] TRIM_RST        = 8'hff;

    // Field layout
    localparam int PRESCALE_MSB   = 1;
    localparam int DELAY_CODE_MSB = 2;
    localparam int STAT_ACTIVE    = 0;
    localparam int STAT_WAITING   = 1;

    // Prescale factors as counter terminal values (factor minus one)
    localparam logic [5:0] DIV1_TERM  = 6'h00;
    localparam logic [5:0] DIV4_TERM  = 6'h03;
    localparam logic [5:0] DIV16_TERM = 6'h0f;
    localparam logic [5:0] DIV64_TERM = 6'h3f;

    // Startup delay timing on the low-power RC oscillator
    localparam int LP_OSC_HZ      = 2000;
    localparam int DELAY_STEP_US  = 250;
    localparam int HALF_PERIOD_US = 1000000 / (2 * LP_OSC_HZ);
    // One delay step is this many oscillator edges (both edges counted)
    localparam int EDGES_PER_STEP = DELAY_STEP_US / HALF_PERIOD_US;

    // Capacitor bank weights in femtofarads, MSB down to LSB halves each bit
    localparam int CAP_MSB_FF = 20000;
    localparam int CAP_LSB_FF = 156;

    // Crystal switch sequencer
    typedef enum logic [1:0] {
        SRC_HF,
        SRC_WAIT_XTAL,
        SRC_XTAL
    } src_state_t;

endpackage

// ==== hdl/start_delay_if.sv ====
`timescale 1ns/1ps
interface start_delay_if;
    logic       ce;
    logic       start;
    logic [2:0] code;
    logic       lp_edge;
    logic       done;

    modport ctl (output ce, output start, output code, output lp_edge, input done);
    modport tmr (input ce, input start, input code, input lp_edge, output done);
endinterface

// ==== hdl/crystal_start_timer.sv ====
`timescale 1ns/1ps
module crystal_start_timer
    import clk_trim_pkg::*;
(
    // Clock and reset
    input  wire logic     clk,
    input  wire logic     rst,
    // Control side
    start_delay_if.tmr    tif
);

    logic [2:0] remain_r;
    logic [1:0] step_edges_r;
    logic       busy_r;
    logic       done_r;

    assign tif.done = done_r;

    // Count oscillator edges down from the programmed code
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            remain_r     <= 3'h0;
            step_edges_r <= 2'h0;
            busy_r       <= 1'b0;
            done_r       <= 1'b0;
        end else if (tif.ce) begin
            if (tif.start) begin
                // A restart discards any earlier count
                remain_r     <= tif.code;
                step_edges_r <= 2'h0;
                busy_r       <= (tif.code != 3'h0);
                done_r       <= (tif.code == 3'h0);
            end else if (busy_r && tif.lp_edge) begin
                if (step_edges_r == 2'(EDGES_PER_STEP - 1)) begin
                    step_edges_r <= 2'h0;
                    remain_r     <= remain_r - 3'h1;
                    if (remain_r == 3'h1) begin
                        busy_r <= 1'b0;
                        done_r <= 1'b1;
                    end
                end else begin
                    step_edges_r <= step_edges_r + 2'h1;
                end
            end
        end
    end

    // Helper: code taken at start and edges seen since
    logic [2:0] code_seen_r;
    logic [3:0] edges_seen_r;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            code_seen_r  <= 3'h0;
            edges_seen_r <= 4'h0;
        end else if (tif.ce) begin
            if (tif.start) begin
                code_seen_r  <= tif.code;
                edges_seen_r <= 4'h0;
            end else if (busy_r && tif.lp_edge) begin
                edges_seen_r <= edges_seen_r + 4'h1;
            end
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    a_zero_delay_done: assert property (tif.ce && tif.start && tif.code == 3'h0 |=> done_r)
        else $error("zero delay code did not finish at once");
    a_delay_edge_count: assert property ($rose(done_r) && code_seen_r != 3'h0 |->
        edges_seen_r == 4'(code_seen_r) * 4'(EDGES_PER_STEP))
        else $error("startup delay ended after wrong number of oscillator edges");

endmodule

// ==== hdl/clock_divider_and_crystal_trim.sv ====
`timescale 1ns/1ps
// Contract
// - Prescale codes 01, 10, 11 divide the selected system clock by 4, 16, 64.
// - Prescale code 00, the reset value, passes the system clock undivided.
// - Prescale register holds the setting in bits 1:0; bits 7:2 reserved.
// - Startup delay is the 3-bit code times 250 us, 0 to 1750 us.
// - Startup delay is timed from the 2 kHz low-power RC oscillator.
// - Delay config holds the code in bits 2:0; bits 7:3 reserved.
// - Switching from HF RC oscillator to crystal waits the programmed delay.
// - FSK with data level 0 applies the low-shift trim byte.
// - FSK with data level 1 applies the high-shift trim byte.
// - ASK with data level 1 applies the high trim byte as centre trim.
// - Each trim byte drives a binary-weighted array, bit 7 20pF to bit 0 156fF.
// - Cap-array short bit set shorts the internal array for external trimming.
module clock_divider_and_crystal_trim
    import clk_trim_pkg::*;
(
    // Clock, reset, enable
    input  wire logic       clk,
    input  wire logic       rst,
    input  wire logic       ce,
    // Register port
    input  wire logic [7:0] addr,
    input  wire logic [7:0] wdata,
    input  wire logic       wr,
    input  wire logic       rd,
    output logic      [7:0] rdata,
    // Oscillators and clock source control
    input  wire logic       hf_osc_tick,
    input  wire logic       xtal_osc_tick,
    input  wire logic       lp_osc_level,
    input  wire logic       system_clock_source_select,
    output logic            sys_clk_tick,
    output logic            crystal_active,
    output logic            hf_osc_enable,
    // Modulation and trimming
    input  wire logic       transmit_data_level,
    input  wire logic       modulation_select,
    input  wire logic       cap_array_short,
    output logic      [7:0] cap_bank_enable,
    output logic            cap_short_enable
);

    // Software registers
    logic [1:0] clock_prescale_select_r;
    logic [2:0] crystal_startup_delay_r;
    logic [7:0] high_trim_register_r;
    logic [7:0] low_trim_register_r;
    logic [7:0] rdata_r;

    // Clock path state
    logic [5:0] div_cnt_r;
    logic [5:0] div_term;
    logic       sys_tick_r;
    logic       lp_prev_r;
    src_state_t src_state_r;
    src_state_t src_state_nxt;
    logic       crystal_active_r;
    logic       hf_enable_r;

    // Trim path state
    logic [7:0] trim_sel;
    logic [7:0] cap_bank_r;
    logic       cap_short_r;

    start_delay_if dif ();

    assign rdata            = rdata_r;
    assign sys_clk_tick     = sys_tick_r;
    assign crystal_active   = crystal_active_r;
    assign hf_osc_enable    = hf_enable_r;
    assign cap_bank_enable  = cap_bank_r;
    assign cap_short_enable = cap_short_r;

    // Register writes; trim bytes are write-only
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            clock_prescale_select_r <= PRESCALE_RST;
            crystal_startup_delay_r <= DELAY_CODE_RST;
            high_trim_register_r    <= TRIM_RST;
            low_trim_register_r     <= TRIM_RST;
        end else if (ce && wr) begin
            unique case (addr)
                PRESCALE_OFS:  clock_prescale_select_r <= wdata[PRESCALE_MSB:0];
                DELAY_CFG_OFS: crystal_startup_delay_r <= wdata[DELAY_CODE_MSB:0];
                HIGH_TRIM_OFS: high_trim_register_r    <= wdata;
                LOW_TRIM_OFS:  low_trim_register_r     <= wdata;
                default:       ;
            endcase
        end
    end

    // Read data stands only in the cycle after the strobe
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            rdata_r <= 8'h00;
        end else if (ce) begin
            rdata_r <= 8'h00;
            if (rd) begin
                unique case (addr)
                    PRESCALE_OFS:   rdata_r <= {6'h00, clock_prescale_select_r};
                    DELAY_CFG_OFS:  rdata_r <= {5'h00, crystal_startup_delay_r};
                    CLK_STATUS_OFS: begin
                        rdata_r[STAT_ACTIVE]  <= crystal_active_r;
                        rdata_r[STAT_WAITING] <= (src_state_r == SRC_WAIT_XTAL);
                    end
                    default:        rdata_r <= 8'h00; // Write-only and unmapped read zero
                endcase
            end
        end
    end

    // Terminal count for the programmed prescale factor
    always_comb begin
        unique case (clock_prescale_select_r)
            2'h0: div_term = DIV1_TERM;
            2'h1: div_term = DIV4_TERM;
            2'h2: div_term = DIV16_TERM;
            2'h3: div_term = DIV64_TERM;
        endcase
    end

    // Prescaler on ticks of whichever source is in use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            div_cnt_r  <= 6'h00;
            sys_tick_r <= 1'b0;
        end else if (ce) begin
            sys_tick_r <= 1'b0;
            if (crystal_active_r ? xtal_osc_tick : hf_osc_tick) begin
                // >= so a smaller factor written mid-count cannot overrun
                if (div_cnt_r >= div_term) begin
                    div_cnt_r  <= 6'h00;
                    sys_tick_r <= 1'b1;
                end else begin
                    div_cnt_r <= div_cnt_r + 6'h01;
                end
            end
        end
    end

    // Both edges of the low-power oscillator mark half periods
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            lp_prev_r <= 1'b0;
        end else if (ce) begin
            lp_prev_r <= lp_osc_level;
        end
    end

    assign dif.ce      = ce;
    assign dif.code    = crystal_startup_delay_r;
    assign dif.lp_edge = lp_osc_level ^ lp_prev_r;
    assign dif.start   = (src_state_r == SRC_HF) && system_clock_source_select;

    crystal_start_timer u_timer (
        .clk (clk),
        .rst (rst),
        .tif (dif.tmr)
    );

    // Source switch sequencer
    always_comb begin
        src_state_nxt = src_state_r;
        unique case (src_state_r)
            SRC_HF:        if (system_clock_source_select) src_state_nxt = SRC_WAIT_XTAL;
            SRC_WAIT_XTAL: begin
                // Dropping the request aborts; the HF oscillator is still running
                if (!system_clock_source_select) src_state_nxt = SRC_HF;
                else if (dif.done)               src_state_nxt = SRC_XTAL;
            end
            SRC_XTAL:      if (!system_clock_source_select) src_state_nxt = SRC_HF;
            // Unused code falls back to the HF source, which is enabled in every state but SRC_XTAL
            default:       src_state_nxt = SRC_HF;
        endcase
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            src_state_r <= SRC_HF;
        end else if (ce) begin
            src_state_r <= src_state_nxt;
        end
    end

    // Registered source outputs; HF powers down only once the crystal is in use
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            crystal_active_r <= 1'b0;
            hf_enable_r      <= 1'b1;
        end else if (ce) begin
            crystal_active_r <= (src_state_nxt == SRC_XTAL);
            hf_enable_r      <= (src_state_nxt != SRC_XTAL);
        end
    end

    // Level 1 in either mode, or ASK at all, uses the high byte
    assign trim_sel = (transmit_data_level || modulation_select) ?
                      high_trim_register_r :
                      low_trim_register_r;

    // One switch per binary-weighted capacitor, re-evaluated every cycle
    genvar i;
    generate
        for (i = 0; i < 8; i++) begin : g_cap
            always_ff @(posedge clk or posedge rst) begin
                if (rst) begin
                    cap_bank_r[i] <= TRIM_RST[i];
                end else if (ce) begin
                    cap_bank_r[i] <= trim_sel[i];
                end
            end
        end
    endgenerate

    // Short the array for external trimming
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cap_short_r <= 1'b0;
        end else if (ce) begin
            cap_short_r <= cap_array_short;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_crystal_requested;
        ce && src_state_r == SRC_HF && system_clock_source_select;
    endsequence

    // Request kept and timer not yet finished; says nothing about the output itself
    sequence s_held_waiting;
        (system_clock_source_select && !dif.done) [*2];
    endsequence

    a_div_by_one: assert property (ce && clock_prescale_select_r == 2'h0 &&
        (crystal_active_r ? xtal_osc_tick : hf_osc_tick) |=> sys_tick_r)
        else $error("undivided clock missed a tick");
    a_div_spacing: assert property (ce && sys_tick_r && clock_prescale_select_r == 2'h1 &&
        $stable(clock_prescale_select_r) |-> div_cnt_r == 6'h00)
        else $error("prescale tick with counter not restarted");
    a_prescale_rsvd: assert property (ce && rd && addr == PRESCALE_OFS |=> rdata_r[7:2] == 6'h00)
        else $error("prescale reserved bits read nonzero");
    a_delay_rsvd: assert property (ce && rd && addr == DELAY_CFG_OFS |=>
        rdata_r == {5'h00, $past(crystal_startup_delay_r)})
        else $error("delay config read wrong");
    a_xtal_waits: assert property (s_crystal_requested ##1 s_held_waiting |-> !crystal_active_r)
        else $error("crystal selected before startup delay");
    a_fsk_low_trim: assert property (ce && !modulation_select && !transmit_data_level |=>
        cap_bank_r == $past(low_trim_register_r))
        else $error("FSK low trim not applied");
    a_fsk_high_trim: assert property (ce && !modulation_select && transmit_data_level |=>
        cap_bank_r == $past(high_trim_register_r))
        else $error("FSK high trim not applied");
    a_ask_centre_trim: assert property (ce && modulation_select && transmit_data_level |=>
        cap_bank_r == $past(high_trim_register_r))
        else $error("ASK centre trim not applied");
    a_cap_short_follows: assert property (ce && cap_array_short |=> cap_short_r)
        else $error("capacitor short not applied");
    a_trim_tracks_level: assert property (ce && $changed(transmit_data_level) && !modulation_select &&
        $stable(low_trim_register_r) && $stable(high_trim_register_r) |=>
        cap_bank_r == (transmit_data_level ? high_trim_register_r : low_trim_register_r))
        else $error("trim did not follow data level change");
    a_hf_xtal_exclusive: assert property (hf_enable_r == !crystal_active_r)
        else $error("HF enable and crystal source disagree");
    a_wait_abort: assert property (ce && src_state_r == SRC_WAIT_XTAL && !system_clock_source_select |=>
        src_state_r == SRC_HF && !crystal_active_r)
        else $error("dropped crystal request did not abort");
    a_div64_wrap: assert property (ce && clock_prescale_select_r == 2'h3 && div_cnt_r == DIV64_TERM &&
        (crystal_active_r ? xtal_osc_tick : hf_osc_tick) |=> sys_tick_r && div_cnt_r == 6'h00)
        else $error("divide by 64 did not wrap with a tick");

endmodule

// ==== dv/clock_divider_and_crystal_trim_tb.sv ====
`timescale 1ns/1ps
module clock_divider_and_crystal_trim_tb;
    import clk_trim_pkg::*;

    logic       clk = 1'b0, rst = 1'b1, ce = 1'b1, wr = 1'b0, rd = 1'b0;
    logic [7:0] addr = 8'h00, wdata = 8'h00;
    logic       hf_osc_tick = 1'b0, xtal_osc_tick = 1'b0, lp_osc_level = 1'b0;
    logic       system_clock_source_select = 1'b0, transmit_data_level = 1'b0;
    logic       modulation_select = 1'b0, cap_array_short = 1'b0;
    logic [7:0] rdata, cap_bank_enable;
    logic       sys_clk_tick, crystal_active, hf_osc_enable, cap_short_enable;
    int         fail_count = 0;
    int         checks = 0;
    logic [7:0] rnd = 8'h3d;
    // Register model: expected contents, reserved bits already masked
    logic [7:0] m_pre = 8'h00, m_dly = 8'h03, m_hi = 8'hff, m_lo = 8'hff;

    clock_divider_and_crystal_trim dut (.clk(clk), .rst(rst), .ce(ce), .addr(addr), .wdata(wdata),
        .wr(wr), .rd(rd), .rdata(rdata), .hf_osc_tick(hf_osc_tick), .xtal_osc_tick(xtal_osc_tick),
        .lp_osc_level(lp_osc_level), .system_clock_source_select(system_clock_source_select),
        .sys_clk_tick(sys_clk_tick), .crystal_active(crystal_active), .hf_osc_enable(hf_osc_enable),
        .transmit_data_level(transmit_data_level), .modulation_select(modulation_select),
        .cap_array_short(cap_array_short), .cap_bank_enable(cap_bank_enable),
        .cap_short_enable(cap_short_enable));

    // Free-running clock, 5 ns period
    always #2.5 clk = ~clk;

    // Next LFSR state, taps 8 6 5 4
    function automatic logic [7:0] lfsr_next(input logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction

    // Random stream from a small LFSR; crystal ticks are noise while unused
    always @(posedge clk) begin
        rnd           <= lfsr_next(rnd);
        xtal_osc_tick <= rnd[0];
    end

    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, fail_count);
        if (fail_count == 0 && checks > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // One-cycle write; the model keeps only the implemented bits
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        case (a)
            PRESCALE_OFS:  m_pre = d & 8'h03;
            DELAY_CFG_OFS: m_dly = d & 8'h07;
            HIGH_TRIM_OFS: m_hi = d;
            LOW_TRIM_OFS:  m_lo = d;
            default: ;
        endcase
    endtask

    // One-cycle read; data is sampled in the single cycle it stands
    task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Gap between successive output ticks with the source ticking every cycle
    task automatic div_test(input logic [1:0] code);
        logic [7:0] d;
        int         t;
        wr_reg(PRESCALE_OFS, {rnd[7:2], code});
        rd_reg(PRESCALE_OFS, d);
        check("prescale readback", d, m_pre);
        hf_osc_tick <= 1'b1;
        for (int p = 0; p < 3; p++) begin
            t = 0;
            do begin
                @(posedge clk);
                #1;
                t++;
            end while (sys_clk_tick !== 1'b1 && t < 200);
        end
        check("divide gap", t[7:0], 8'h01 << (2 * code));
        hf_osc_tick <= 1'b0;
    endtask

    // Crystal request; lp level toggles every 8 cycles, each toggle is one step
    task automatic xtal_test(input logic [2:0] k);
        logic [7:0] d;
        int         t, e;
        wr_reg(DELAY_CFG_OFS, {rnd[7:3], k});
        rd_reg(DELAY_CFG_OFS, d);
        check("delay readback", d, m_dly);
        @(posedge clk);
        system_clock_source_select <= 1'b1;
        t = 0;
        e = 0;
        do begin
            @(posedge clk);
            t++;
            if (t % 8 == 0) begin
                lp_osc_level <= ~lp_osc_level;
                e++;
            end
            #1;
        end while (crystal_active !== 1'b1 && t < 100);
        check("lp steps waited", e[7:0], {5'h00, k});
        check("hf enable off", {7'h00, hf_osc_enable}, 8'h00);
        rd_reg(CLK_STATUS_OFS, d);
        check("status active", d, 8'h01);
        @(posedge clk);
        system_clock_source_select <= 1'b0;
        repeat (3) @(posedge clk);
        #1;
        check("crystal released", {crystal_active, hf_osc_enable}, 2'b01);
    endtask

    // Trim byte choice follows level and modulation with no rewrite
    task automatic trim_test;
        logic [7:0] d;
        logic       sh;
        wr_reg(HIGH_TRIM_OFS, rnd);
        wr_reg(LOW_TRIM_OFS, ~rnd);
        rd_reg(HIGH_TRIM_OFS, d);
        check("write-only read", d, 8'h00);
        for (int i = 0; i < 8; i++) begin
            sh = rnd[1];
            @(posedge clk);
            transmit_data_level <= i[0];
            modulation_select   <= i[1];
            cap_array_short     <= sh;
            repeat (2) @(posedge clk);
            #1;
            check("cap bank", cap_bank_enable, (i[0] | i[1]) ? m_hi : m_lo);
            check("cap short", {7'h00, cap_short_enable}, {7'h00, sh});
        end
    endtask

    // Watchdog sized well above the longest test sequence
    initial begin
        #(20000 * 5);
        fail_count++;
        $display("Error watchdog expired");
        report_and_stop();
    end

    initial begin
        logic [7:0] d;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        #1;
        check("reset cap bank", cap_bank_enable, TRIM_RST);
        check("reset hf enable", {7'h00, hf_osc_enable}, 8'h01);
        rd_reg(PRESCALE_OFS, d);
        check("reset prescale", d, m_pre);
        rd_reg(DELAY_CFG_OFS, d);
        check("reset delay", d, m_dly);
        wr_reg(8'h10, 8'h5a);
        rd_reg(8'h10, d);
        check("unmapped read", d, 8'h00);
        // Write with the enable low must be ignored
        @(posedge clk);
        ce    <= 1'b0;
        addr  <= PRESCALE_OFS;
        wdata <= 8'h03;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        ce    <= 1'b1;
        rd_reg(PRESCALE_OFS, d);
        check("frozen prescale", d, m_pre);
        $display("test registers done");
        for (int c = 0; c < 4; c++)
            div_test(c[1:0]);
        div_test(2'h0);
        $display("test divider done");
        for (int k = 0; k < 8; k++)
            xtal_test(k[2:0]);
        $display("test crystal delay done");
        trim_test();
        $display("test trim done");
        report_and_stop();
    end
endmodule
